// ### pkg/alu8_pkg.sv
// Shared constants, opcodes and state encoding for the 8-bit arithmetic and logic unit
package alu8_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] DEST_OFS = 8'h04;
   localparam logic [7:0] SRC_OFS = 8'h08;
   localparam logic [7:0] FLAGS_OFS = 8'h0c;
   localparam logic [7:0] RESULT_OFS = 8'h10;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int unsigned OP_W = 5;
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;

   // ****************************************
   // Values after reset and fixed operands
   // ****************************************
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [31:0] ZERO_BUS = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;

   // ****************************************
   // Cycle counts per operation class
   // ****************************************
   localparam int unsigned SHORT_OP_CYCLES = 1;
   localparam int unsigned LONG_OP_CYCLES = 2;

   typedef enum logic [4:0] {
      OP_ADD = 5'h00,
      OP_ADD_CARRY = 5'h01,
      OP_ADD_IMM_PAIR = 5'h02,
      OP_SUB_REGS = 5'h03,
      OP_SUB_IMM = 5'h04,
      OP_SUB_REGS_BORROW = 5'h05,
      OP_SUB_IMM_BORROW = 5'h06,
      OP_SUB_IMM_PAIR = 5'h07,
      OP_AND = 5'h08,
      OP_OR = 5'h09,
      OP_XOR_REGS = 5'h0a,
      OP_ONES_COMPLEMENT = 5'h0b,
      OP_TWOS_COMPLEMENT = 5'h0c,
      OP_SET_MASK_BITS = 5'h0d,
      OP_CLEAR_MASK_BITS = 5'h0e,
      OP_PLUS_ONE = 5'h0f,
      OP_MINUS_ONE = 5'h10,
      OP_ZERO_MINUS_CHECK = 5'h11,
      OP_ZERO_REGISTER = 5'h12,
      OP_ALL_ONES_REGISTER = 5'h13,
      OP_MULT_UNSIGNED = 5'h14,
      OP_MULT_SIGNED = 5'h15
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC1 = 2'b01,
      ST_EXEC2 = 2'b11
   } state_e;

endpackage : alu8_pkg

// ### core/byte_adder.sv
// Eight-bit add or subtract with carry, half carry and overflow
`timescale 1ns/1ps
module byte_adder (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   input wire logic sub,
   output logic [7:0] sum,
   output logic cout,
   output logic half,
   output logic ovf
);
   logic [7:0] b_eff;
   logic c_eff;
   logic [8:0] full;
   logic [4:0] low;

   // Subtraction as a + ~b + ~borrow; carries inverted back into borrows
   always_comb begin
      b_eff = sub ? ~b : b;
      c_eff = sub ? ~cin : cin;
      full = {1'b0, a} + {1'b0, b_eff} + {8'h00, c_eff};
      low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
      sum = full[7:0];
      cout = sub ? ~full[8] : full[8];
      half = sub ? ~low[4] : low[4];
      ovf = (a[7] == b_eff[7]) && (full[7] != a[7]);
   end
endmodule : byte_adder

// ### core/arith_logic_unit_8bit.sv
// Eight-bit arithmetic and logic unit behind an AHB-Lite register slave
//
// Notes on behaviour
// - Add source to destination, optionally with carry; Z,C,N,V,H; one cycle.
// - Add constant to register pair; Z,C,N,V,S; two cycles.
// - Subtract source from destination, optionally with carry; Z,C,N,V,H; one cycle.
// - Subtract constant from destination, optionally with carry; Z,C,N,V,H; one cycle.
// - Subtract constant from register pair; Z,C,N,V,S; two cycles.
// - AND destination with source or constant; only Z,N,V; one cycle.
// - OR destination with source or constant; only Z,N,V; one cycle.
// - XOR two registers into destination; Z,N,V; one cycle.
// - Ones complement 0xFF minus value; twos complement 0x00 minus value, adds H.
// - Set bits ORs mask in; clear bits ANDs with 0xFF minus mask; Z,N,V.
// - Test ANDs destination with itself, value kept, Z,N,V flagged.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module arith_logic_unit_8bit (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp
);

   // ****************************************
   // Declarations
   // ****************************************
   alu8_pkg::state_e state, next_state;
   alu8_pkg::op_e op, next_op;
   logic [15:0] dest, next_dest;
   logic [7:0] src, next_src;
   logic [7:0] flags, next_flags;
   logic [15:0] result, next_result;
   logic wr_pend, next_wr_pend;
   logic rd_pend, next_rd_pend;
   logic [7:0] addr_q, next_addr_q;
   logic [31:0] next_hrdata;
   logic next_hreadyout;
   logic take;
   logic wr_do;
   logic start;
   logic is_long;
   logic [31:0] read_mux;
   logic [7:0] a_in, b_in;
   logic c_in, sub_in;
   logic [7:0] lo_sum, hi_sum;
   logic lo_cout, lo_half, lo_ovf;
   logic hi_cout, hi_ovf;
   logic [15:0] prod_u;
   logic signed [15:0] prod_s;
   logic [15:0] alu_res;
   logic [7:0] alu_flags;
   logic alu_wide;
   logic [7:0] r8;
   logic [15:0] pair;

   // ****************************************
   // Bus slave
   // ****************************************
   // Only word transfers are expected; hsize is not decoded
   assign take = hsel && htrans[1] && hready;
   assign wr_do = wr_pend && hreadyout;

   always_comb begin
      read_mux = alu8_pkg::ZERO_BUS;
      case (addr_q)
         alu8_pkg::CMD_OFS: read_mux = {27'h0, op};
         alu8_pkg::DEST_OFS: read_mux = {16'h0, dest};
         alu8_pkg::SRC_OFS: read_mux = {24'h0, src};
         alu8_pkg::FLAGS_OFS: read_mux = {24'h0, flags};
         alu8_pkg::RESULT_OFS: read_mux = {16'h0, result};
         default: read_mux = alu8_pkg::ZERO_BUS;
      endcase
   end

   // Reads wait one cycle so a write just finished is always seen
   always_comb begin
      next_wr_pend = wr_pend;
      next_rd_pend = rd_pend;
      next_addr_q = addr_q;
      next_hrdata = hrdata;
      if (wr_do) begin
         next_wr_pend = 1'b0;
      end
      if (rd_pend && state == alu8_pkg::ST_IDLE) begin
         next_hrdata = read_mux;
         next_rd_pend = 1'b0;
      end
      if (take) begin
         next_addr_q = haddr[7:0];
         next_wr_pend = hwrite;
         next_rd_pend = !hwrite;
      end
      // The bus stalls while an operation runs
      next_hreadyout = (next_state == alu8_pkg::ST_IDLE) && !next_rd_pend;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= alu8_pkg::ZERO_BYTE;
         hrdata <= alu8_pkg::ZERO_BUS;
         hreadyout <= 1'b1;
         hresp <= alu8_pkg::RESP_OKAY;
      end else begin
         wr_pend <= next_wr_pend;
         rd_pend <= next_rd_pend;
         addr_q <= next_addr_q;
         hrdata <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp <= alu8_pkg::RESP_OKAY;
      end
   end

   // ****************************************
   // Datapath
   // ****************************************
   assign pair = {hi_sum, lo_sum};
   assign prod_u = dest[7:0] * src;
   assign prod_s = $signed(dest[7:0]) * $signed(src);

   byte_adder lo_add (
      .a(a_in),
      .b(b_in),
      .cin(c_in),
      .sub(sub_in),
      .sum(lo_sum),
      .cout(lo_cout),
      .half(lo_half),
      .ovf(lo_ovf)
   );

   // High byte of a pair only takes the low byte's carry or borrow
   byte_adder hi_add (
      .a(dest[15:8]),
      .b(alu8_pkg::ZERO_BYTE),
      .cin(lo_cout),
      .sub(sub_in),
      .sum(hi_sum),
      .cout(hi_cout),
      .half(),
      .ovf(hi_ovf)
   );

   always_comb begin
      a_in = dest[7:0];
      b_in = src;
      c_in = 1'b0;
      sub_in = 1'b0;
      case (op)
         alu8_pkg::OP_ADD_CARRY: c_in = flags[alu8_pkg::FLAG_C];
         alu8_pkg::OP_SUB_REGS,
         alu8_pkg::OP_SUB_IMM,
         alu8_pkg::OP_SUB_IMM_PAIR: sub_in = 1'b1;
         alu8_pkg::OP_SUB_REGS_BORROW,
         alu8_pkg::OP_SUB_IMM_BORROW: begin
            sub_in = 1'b1;
            c_in = flags[alu8_pkg::FLAG_C];
         end
         alu8_pkg::OP_TWOS_COMPLEMENT: begin
            a_in = alu8_pkg::ZERO_BYTE;
            b_in = dest[7:0];
            sub_in = 1'b1;
         end
         alu8_pkg::OP_PLUS_ONE: b_in = alu8_pkg::ONE_BYTE;
         alu8_pkg::OP_MINUS_ONE: begin
            b_in = alu8_pkg::ONE_BYTE;
            sub_in = 1'b1;
         end
         default: c_in = 1'b0;
      endcase
   end

   always_comb begin
      r8 = lo_sum;
      alu_flags = flags;
      alu_wide = 1'b0;
      case (op)
         alu8_pkg::OP_AND: r8 = dest[7:0] & src;
         alu8_pkg::OP_OR, alu8_pkg::OP_SET_MASK_BITS: r8 = dest[7:0] | src;
         alu8_pkg::OP_XOR_REGS: r8 = dest[7:0] ^ src;
         alu8_pkg::OP_ONES_COMPLEMENT: r8 = alu8_pkg::ALL_ONES - dest[7:0];
         alu8_pkg::OP_CLEAR_MASK_BITS: r8 = dest[7:0] & (alu8_pkg::ALL_ONES - src);
         alu8_pkg::OP_ZERO_MINUS_CHECK: r8 = dest[7:0] & dest[7:0];
         alu8_pkg::OP_ZERO_REGISTER: r8 = dest[7:0] ^ dest[7:0];
         alu8_pkg::OP_ALL_ONES_REGISTER: r8 = alu8_pkg::ALL_ONES;
         default: r8 = lo_sum;
      endcase
      alu_res = {8'h00, r8};
      case (op)
         alu8_pkg::OP_ADD, alu8_pkg::OP_ADD_CARRY, alu8_pkg::OP_SUB_REGS, alu8_pkg::OP_SUB_IMM,
         alu8_pkg::OP_SUB_REGS_BORROW, alu8_pkg::OP_SUB_IMM_BORROW, alu8_pkg::OP_TWOS_COMPLEMENT: begin
            alu_flags[alu8_pkg::FLAG_C] = lo_cout;
            alu_flags[alu8_pkg::FLAG_Z] = (r8 == alu8_pkg::ZERO_BYTE);
            alu_flags[alu8_pkg::FLAG_N] = r8[7];
            alu_flags[alu8_pkg::FLAG_V] = lo_ovf;
            alu_flags[alu8_pkg::FLAG_H] = lo_half;
            // Borrow forms keep zero only if it was already set, for chained compares
            if (op == alu8_pkg::OP_SUB_REGS_BORROW || op == alu8_pkg::OP_SUB_IMM_BORROW) begin
               alu_flags[alu8_pkg::FLAG_Z] = (r8 == alu8_pkg::ZERO_BYTE) && flags[alu8_pkg::FLAG_Z];
            end
         end
         alu8_pkg::OP_AND, alu8_pkg::OP_OR, alu8_pkg::OP_XOR_REGS, alu8_pkg::OP_SET_MASK_BITS,
         alu8_pkg::OP_CLEAR_MASK_BITS, alu8_pkg::OP_ZERO_MINUS_CHECK, alu8_pkg::OP_ZERO_REGISTER: begin
            alu_flags[alu8_pkg::FLAG_Z] = (r8 == alu8_pkg::ZERO_BYTE);
            alu_flags[alu8_pkg::FLAG_N] = r8[7];
            alu_flags[alu8_pkg::FLAG_V] = 1'b0;
         end
         alu8_pkg::OP_ONES_COMPLEMENT: begin
            alu_flags[alu8_pkg::FLAG_C] = 1'b1;
            alu_flags[alu8_pkg::FLAG_Z] = (r8 == alu8_pkg::ZERO_BYTE);
            alu_flags[alu8_pkg::FLAG_N] = r8[7];
            alu_flags[alu8_pkg::FLAG_V] = 1'b0;
         end
         alu8_pkg::OP_PLUS_ONE, alu8_pkg::OP_MINUS_ONE: begin
            alu_flags[alu8_pkg::FLAG_Z] = (r8 == alu8_pkg::ZERO_BYTE);
            alu_flags[alu8_pkg::FLAG_N] = r8[7];
            alu_flags[alu8_pkg::FLAG_V] = lo_ovf;
         end
         alu8_pkg::OP_ADD_IMM_PAIR, alu8_pkg::OP_SUB_IMM_PAIR: begin
            alu_res = pair;
            alu_wide = 1'b1;
            alu_flags[alu8_pkg::FLAG_C] = hi_cout;
            alu_flags[alu8_pkg::FLAG_Z] = (pair == alu8_pkg::ZERO_WORD);
            alu_flags[alu8_pkg::FLAG_N] = pair[15];
            alu_flags[alu8_pkg::FLAG_V] = hi_ovf;
            alu_flags[alu8_pkg::FLAG_S] = pair[15] ^ hi_ovf;
         end
         alu8_pkg::OP_MULT_UNSIGNED, alu8_pkg::OP_MULT_SIGNED: begin
            alu_res = (op == alu8_pkg::OP_MULT_SIGNED) ? prod_s : prod_u;
            alu_flags[alu8_pkg::FLAG_C] = alu_res[15];
            alu_flags[alu8_pkg::FLAG_Z] = (alu_res == alu8_pkg::ZERO_WORD);
         end
         default: alu_flags = flags;
      endcase
   end

   // ****************************************
   // Sequencer and operand registers
   // ****************************************
   assign is_long = (op == alu8_pkg::OP_ADD_IMM_PAIR) || (op == alu8_pkg::OP_SUB_IMM_PAIR) ||
                    (op == alu8_pkg::OP_MULT_UNSIGNED) || (op == alu8_pkg::OP_MULT_SIGNED);
   assign start = wr_do && (addr_q == alu8_pkg::CMD_OFS) && (state == alu8_pkg::ST_IDLE);

   always_comb begin
      next_state = state;
      next_op = op;
      next_dest = dest;
      next_src = src;
      next_flags = flags;
      next_result = result;
      case (state)
         alu8_pkg::ST_IDLE: begin
            if (start) begin
               next_op = alu8_pkg::op_e'(hwdata[alu8_pkg::OP_W-1:0]);
               next_state = alu8_pkg::ST_EXEC1;
            end else if (wr_do && addr_q == alu8_pkg::DEST_OFS) begin
               next_dest = hwdata[15:0];
            end else if (wr_do && addr_q == alu8_pkg::SRC_OFS) begin
               next_src = hwdata[7:0];
            end else if (wr_do && addr_q == alu8_pkg::FLAGS_OFS) begin
               next_flags = hwdata[7:0];
            end
         end
         alu8_pkg::ST_EXEC1, alu8_pkg::ST_EXEC2: begin
            // Long operations commit on the second cycle
            if (state == alu8_pkg::ST_EXEC1 && is_long) begin
               next_state = alu8_pkg::ST_EXEC2;
            end else begin
               next_state = alu8_pkg::ST_IDLE;
               next_result = alu_res;
               next_flags = alu_flags;
               if (alu_wide) begin
                  next_dest = alu_res;
               end else if (op != alu8_pkg::OP_MULT_UNSIGNED && op != alu8_pkg::OP_MULT_SIGNED) begin
                  next_dest = {dest[15:8], alu_res[7:0]};
               end
            end
         end
         default: next_state = alu8_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= alu8_pkg::ST_IDLE;
         op <= alu8_pkg::OP_ADD;
         dest <= alu8_pkg::ZERO_WORD;
         src <= alu8_pkg::ZERO_BYTE;
         flags <= alu8_pkg::ZERO_BYTE;
         result <= alu8_pkg::ZERO_WORD;
      end else begin
         state <= next_state;
         op <= next_op;
         dest <= next_dest;
         src <= next_src;
         flags <= next_flags;
         result <= next_result;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   short_done_a: assert property (state == alu8_pkg::ST_EXEC1 && !is_long |=> state == alu8_pkg::ST_IDLE)
      else $error("short operation did not finish in one cycle");
   long_done_a: assert property (state == alu8_pkg::ST_EXEC1 && is_long
      |=> state == alu8_pkg::ST_EXEC2 ##1 state == alu8_pkg::ST_IDLE)
      else $error("long operation did not finish in two cycles");
   add_carry_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_ADD_CARRY
      |=> result[7:0] == 8'($past(dest[7:0]) + $past(src) + {7'h0, $past(flags[alu8_pkg::FLAG_C])}))
      else $error("add with carry gave a wrong sum");
   pair_add_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_ADD_IMM_PAIR
      |=> ##1 result == 16'($past(dest, 2) + {8'h00, $past(src, 2)})
      && flags[alu8_pkg::FLAG_S] == (flags[alu8_pkg::FLAG_N] ^ flags[alu8_pkg::FLAG_V]))
      else $error("pair add result or sign flag wrong");
   sub_borrow_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_SUB_REGS_BORROW
      |=> flags[alu8_pkg::FLAG_C] == ({1'b0, $past(dest[7:0])} < 9'({1'b0, $past(src)} +
      {8'h00, $past(flags[alu8_pkg::FLAG_C])})))
      else $error("subtract with borrow gave a wrong carry");
   sub_imm_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_SUB_IMM
      |=> result[7:0] == 8'($past(dest[7:0]) - $past(src)) && flags[alu8_pkg::FLAG_Z] == (result[7:0] == 8'h00))
      else $error("subtract constant result or zero flag wrong");
   pair_sub_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_SUB_IMM_PAIR
      |=> ##1 result == 16'($past(dest, 2) - {8'h00, $past(src, 2)})
      && flags[alu8_pkg::FLAG_C] == ($past(dest, 2) < {8'h00, $past(src, 2)}))
      else $error("pair subtract result or borrow wrong");
   and_flags_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_AND
      |=> result[7:0] == ($past(dest[7:0]) & $past(src)) && !flags[alu8_pkg::FLAG_V]
      && flags[alu8_pkg::FLAG_C] == $past(flags[alu8_pkg::FLAG_C]))
      else $error("and result or flags wrong");
   or_result_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_OR
      |=> dest[7:0] == ($past(dest[7:0]) | $past(src)))
      else $error("or result not written back");
   xor_result_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_XOR_REGS
      |=> result[7:0] == ($past(dest[7:0]) ^ $past(src)) && flags[alu8_pkg::FLAG_N] == result[7])
      else $error("xor result or negative flag wrong");
   negate_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_TWOS_COMPLEMENT
      |=> result[7:0] == 8'(8'h00 - $past(dest[7:0])) && flags[alu8_pkg::FLAG_C] == ($past(dest[7:0]) != 8'h00))
      else $error("twos complement result or carry wrong");
   mask_clear_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_CLEAR_MASK_BITS
      |=> result[7:0] == ($past(dest[7:0]) & ~$past(src)))
      else $error("clear mask bits result wrong");
   test_keep_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_ZERO_MINUS_CHECK
      |=> dest == $past(dest) && flags[alu8_pkg::FLAG_Z] == (dest[7:0] == 8'h00))
      else $error("test changed the register or missed zero");
   ones_keep_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_ALL_ONES_REGISTER
      |=> flags == $past(flags) && dest[7:0] == 8'hff)
      else $error("set register touched flags or missed ones");
   mult_signed_a: assert property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_MULT_SIGNED
      |=> ##1 result == 16'($signed($past(dest[7:0], 2)) * $signed($past(src, 2)))
      && flags[alu8_pkg::FLAG_C] == result[15])
      else $error("signed product or carry wrong");

   pair_seen_c: cover property (state == alu8_pkg::ST_EXEC2 && op == alu8_pkg::OP_SUB_IMM_PAIR);
   mult_seen_c: cover property (state == alu8_pkg::ST_EXEC2 && op == alu8_pkg::OP_MULT_UNSIGNED);
   stall_read_c: cover property (rd_pend && state == alu8_pkg::ST_EXEC1);
   carry_chain_c: cover property (state == alu8_pkg::ST_EXEC1 && op == alu8_pkg::OP_ADD_CARRY
      && flags[alu8_pkg::FLAG_C]);

endmodule : arith_logic_unit_8bit

// ### dv/bus_host.sv
// Bus host model standing in for the bus master and address decoder
`timescale 1ns/1ps
module bus_host (
   input wire logic hclk,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // ****************************************
   // One single word transfer
   // ****************************************
   // Called just after a rising edge; returns at the edge that ends the data phase
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      // Released lines carry inverted values so stale data cannot pass
      haddr <= ~a;
      hwdata <= w ? d : ~d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      hwdata <= ~d;
   endtask : xfer
endmodule : bus_host

// ### dv/arith_logic_unit_8bit_test.sv
// Self-checking bench for the 8-bit arithmetic and logic unit
`timescale 1ns/1ps
module arith_logic_unit_8bit_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel;
   logic hwrite;
   logic hreadyout;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [1:0] htrans;
   logic [1:0] hresp;
   logic [2:0] hsize;
   int failures = 0;
   int n_checks = 0;
   logic [4:0] tops[3] = '{5'h00, 5'h02, 5'h14};
   typedef struct {logic [15:0] d; logic [7:0] s; logic [7:0] fi; logic [15:0] r; logic [7:0] fo;} row_s;
   // Row index is the opcode
   row_s rows[22] = '{
      '{16'h0008, 8'h08, 8'h00, 16'h0010, 8'h20},
      '{16'h007f, 8'h00, 8'h01, 16'h0080, 8'h2c},
      '{16'hffff, 8'h01, 8'h20, 16'h0000, 8'h23},
      '{16'h0010, 8'h01, 8'h00, 16'h000f, 8'h20},
      '{16'h0000, 8'h01, 8'h00, 16'h00ff, 8'h25},
      '{16'h0005, 8'h04, 8'h03, 16'h0000, 8'h02},
      '{16'h0005, 8'h05, 8'h00, 16'h0000, 8'h00},
      '{16'h0000, 8'h01, 8'h00, 16'hffff, 8'h15},
      '{16'h0080, 8'hc0, 8'h29, 16'h0080, 8'h25},
      '{16'h0000, 8'h00, 8'h08, 16'h0000, 8'h02},
      '{16'h00aa, 8'hff, 8'h01, 16'h0055, 8'h01},
      '{16'h0000, 8'h00, 8'h00, 16'h00ff, 8'h05},
      '{16'h0080, 8'h00, 8'h00, 16'h0080, 8'h0d},
      '{16'h0001, 8'h80, 8'h00, 16'h0081, 8'h04},
      '{16'h00ff, 8'hff, 8'h08, 16'h0000, 8'h02},
      '{16'h007f, 8'h00, 8'h01, 16'h0080, 8'h0d},
      '{16'h0080, 8'h00, 8'h00, 16'h007f, 8'h08},
      '{16'h0000, 8'h00, 8'h20, 16'h0000, 8'h22},
      '{16'h005a, 8'h00, 8'h0c, 16'h0000, 8'h02},
      '{16'h0000, 8'h00, 8'h3f, 16'h00ff, 8'h3f},
      '{16'h00ff, 8'hff, 8'h00, 16'hfe01, 8'h01},
      '{16'h00ff, 8'h01, 8'h00, 16'hffff, 8'h01}
   };

   always #2 hclk = ~hclk;

   arith_logic_unit_8bit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));
   bus_host host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      host.xfer(1'b1, {24'h000000, a}, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      host.xfer(1'b0, {24'h000000, a}, 32'h0000_0000, q);
   endtask : rd

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] q;
      longint t0;
      longint span[3];
      // Reset values only appear after the first rising edge has been seen
      @(negedge hclk);
      check(hreadyout, 32'h1, "ready in reset");
      check(hrdata, 32'h0, "read data in reset");
      @(posedge hclk);
      hresetn <= 1'b1;
      rd(alu8_pkg::FLAGS_OFS, q);
      check(q, 32'h0, "flags after reset");
      $display("test reset done");
      foreach (rows[i]) begin
         wr(alu8_pkg::DEST_OFS, {16'h0000, rows[i].d});
         wr(alu8_pkg::SRC_OFS, {24'h000000, rows[i].s});
         wr(alu8_pkg::FLAGS_OFS, {24'h000000, rows[i].fi});
         wr(alu8_pkg::CMD_OFS, 32'(i));
         rd(alu8_pkg::RESULT_OFS, q);
         check(q, {16'h0000, rows[i].r}, $sformatf("result op %0d", i));
         rd(alu8_pkg::FLAGS_OFS, q);
         check(q, {24'h000000, rows[i].fo}, $sformatf("flags op %0d", i));
         rd(alu8_pkg::DEST_OFS, q);
         check(q, {16'h0000, (i >= 20) ? rows[i].d : rows[i].r}, $sformatf("dest op %0d", i));
      end
      $display("test rows done");
      // Long ops must stall the following read exactly one cycle longer
      foreach (tops[i]) begin
         wr(alu8_pkg::CMD_OFS, {27'h0, tops[i]});
         t0 = $time;
         rd(alu8_pkg::RESULT_OFS, q);
         span[i] = $time - t0;
      end
      check(32'(span[1] - span[0]), 32'd4, "pair op cycles");
      check(32'(span[2] - span[0]), 32'd4, "multiply cycles");
      check(32'(span[0]), 32'd16, "short op read span");
      $display("test timing done");
      wr(8'h20, 32'hffff_ffff);
      rd(8'h20, q);
      check(q, 32'h0, "unmapped read");
      check({30'h0, hresp}, 32'h0, "response okay");
      $display("test unmapped done");
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      rd(alu8_pkg::DEST_OFS, q);
      check(q, 32'h0, "dest after second reset");
      $display("test second reset done");
      report_and_stop();
   end

   initial begin
      #20000;
      failures++;
      $display("MISMATCH %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule : arith_logic_unit_8bit_test
